// ---- design/sac_pkg.sv ----
// Package of constants and carrier types for the converter control interface
//
// Function
// - Write, read and sample/hold strobes act only while chip select is low.
// - Chip select and read low drive the data bus and clear the interrupt.
// - Write rising edge starts a conversion; acquisition end is timed internally.
// - Sample/hold falling opens acquisition; its rising edge holds and converts.
// - Calibration request low with chip select high resets and runs a correction-storing calibration.
// - Offset-null request low adds 26 clock periods to a write-started conversion.
// - Conversion-active is low through offset nulling, bit trials and calibration.
// - Interrupt falls on a latched result, rises on read or new start.
// - Result is read as two bytes, high byte first then low byte.
// - Result is two's complement, bit 12 sign, bit 11 magnitude MSB.
// - Calibration pulse drops conversion-active for 1399 clock periods.
// - Write start with offset null: 26 clocks nulling, then 6 clocks sampling.
// - With offset null, acquisition begins when conversion-active rises.
// - Sign resolved first, then magnitude bits trialled MSB down.
// - After the last bit, latch result, drop interrupt, raise conversion-active.
// - First read: lines 0-2 bits 8-10, line 3 MSB, lines 4-7 sign.
// - Second read: lines 0-7 carry result bits 0-7.
// - Read and sample/hold high, select and calibration low: test state drive.
// - A new start resets the sequence; host avoids it mid-conversion.
// - Calibration runs to completion; one runs at power-up.
// - Write-started acquisition without offset null ends 6 clocks after the synchronised write edge.
`default_nettype none
package sac_pkg;
    // ****************************************************************
    // Timing counts in conversion clock periods, result width and bit positions, test-state mask
    // ****************************************************************
    localparam logic [10:0] SAC_CAL_CYCLES    = 11'd1399;
    localparam logic [10:0] SAC_NULL_CYCLES   = 11'd26;
    localparam logic [10:0] SAC_ACQ_CYCLES    = 11'd6;
    localparam logic [10:0] SAC_TRIAL_CYCLES  = 11'd13;
    localparam int          SAC_RES_W         = 13;
    localparam int          SAC_SIGN_BIT      = 12;
    localparam int          SAC_MSB_BIT       = 11;
    localparam logic [7:0]  SAC_TEST_MASK     = 8'h6c;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic chip_select_n;
        logic read_n;
        logic write_n;
        logic sample_hold_n;
        logic calibrate_n;
        logic offset_null_request_n;
    } sac_ctrl_t;

    typedef struct packed {
        logic [7:0] data_bus_line_o;
        logic [7:0] data_bus_line_oe;
    } sac_bus_t;
endpackage
`default_nettype wire

// ---- design/sac_ctrl.sv ----
// Sequencer, bit trial and byte readout of the converter control interface
`default_nettype none
module sac_ctrl
    import sac_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              clk_en,
    input  wire sac_ctrl_t         ctrl_in,
    input  wire logic              comparator_high,
    output var  sac_bus_t          bus_out,
    output var  logic [SAC_RES_W-1:0] trial_value,
    output var  logic              conv_active_n,
    output var  logic              result_ready_n,
    output var  logic              sampling,
    output var  logic              calibrating
);
    typedef enum logic [2:0] {
        ST_CAL, ST_IDLE, ST_NULL, ST_ACQ, ST_SH_ACQ, ST_TRIAL
    } sac_state_t;

    // ****************************************************************
    // State decoding
    // ****************************************************************
    // Conversion-active is low in these states
    function automatic logic busy_state(input sac_state_t s);
        return (s == ST_CAL) || (s == ST_TRIAL) || (s == ST_NULL);
    endfunction

    // Acquisition is open in these states
    function automatic logic acq_state(input sac_state_t s);
        return (s == ST_ACQ) || (s == ST_SH_ACQ);
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int NIN = 6;
    logic [NIN-1:0] s1_q;
    logic [NIN-1:0] s2_q;
    logic [NIN-1:0] s3_q;
    // Only the agreed value is used, so a single-stage glitch is dropped
    logic [NIN-1:0] cur_q;
    logic [NIN-1:0] raw;
    assign raw = ctrl_in;

    // Three stages; a change counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < NIN; g++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    s1_q[g]  <= 1'b1;
                    s2_q[g]  <= 1'b1;
                    s3_q[g]  <= 1'b1;
                    cur_q[g] <= 1'b1;
                end else if (clk_en) begin
                    s1_q[g] <= raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        cur_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Edge history
    // ****************************************************************
    logic [NIN-1:0] prev_q;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            prev_q <= '1;
        end else if (clk_en) begin
            prev_q <= cur_q;
        end
    end

    sac_ctrl_t c, p;
    assign c = cur_q;
    assign p = prev_q;

    // ****************************************************************
    // Edge decoding
    // ****************************************************************
    logic sel;
    logic wr_rise;
    logic sh_fall;
    logic sh_rise;
    logic rd_rise;
    logic cal_req;
    logic test_mode;
    assign sel       = !c.chip_select_n;
    assign wr_rise   = sel && c.write_n && !p.write_n;
    assign sh_fall   = sel && !c.sample_hold_n && p.sample_hold_n;
    assign sh_rise   = sel && c.sample_hold_n && !p.sample_hold_n;
    // Read end is qualified with select where the pointer uses it
    assign rd_rise   = c.read_n && !p.read_n;
    assign cal_req   = !c.calibrate_n && c.chip_select_n;
    assign test_mode = sel && !c.calibrate_n && c.read_n && c.sample_hold_n;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    sac_state_t  st_q;
    logic [10:0] cnt_q;
    logic [3:0]  bit_q;
    logic [SAC_RES_W-1:0] sar_q;
    logic [SAC_RES_W-1:0] result_q;
    logic        done;
    logic        start;
    assign start = wr_rise || sh_fall || sh_rise;

    // Calibration cannot be interrupted, so starts are ignored there
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_q  <= ST_CAL;
            cnt_q <= '0;
            bit_q <= '0;
            sar_q <= '0;
        end else if (clk_en) begin
            cnt_q <= cnt_q + 11'd1;
            case (st_q)
                ST_CAL: begin
                    if (cnt_q == SAC_CAL_CYCLES - 11'd1) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    if (cal_req) begin
                        st_q  <= ST_CAL;
                        cnt_q <= '0;
                    end else if (wr_rise) begin
                        st_q  <= c.offset_null_request_n ? ST_ACQ : ST_NULL;
                        cnt_q <= '0;
                    end else if (sh_fall) begin
                        st_q  <= ST_SH_ACQ;
                    end else if (sh_rise) begin
                        st_q  <= ST_TRIAL;
                        cnt_q <= '0;
                        bit_q <= 4'(SAC_SIGN_BIT);
                        sar_q <= '0;
                    end else begin
                        case (st_q)
                            ST_NULL: begin
                                if (cnt_q == SAC_NULL_CYCLES - 11'd1) begin
                                    st_q  <= ST_ACQ;
                                    cnt_q <= '0;
                                end
                            end
                            ST_ACQ: begin
                                // Counted from the synchronised edge, so pin latency adds on
                                if (cnt_q == SAC_ACQ_CYCLES - 11'd1) begin
                                    st_q  <= ST_TRIAL;
                                    bit_q <= 4'(SAC_SIGN_BIT);
                                    sar_q <= '0;
                                end
                            end
                            ST_TRIAL: begin
                                // Sign set high for negative, magnitude kept if comparator_high differs from the sign bit
                                if (bit_q == 4'(SAC_SIGN_BIT)) begin
                                    sar_q[SAC_SIGN_BIT] <= !comparator_high;
                                end else begin
                                    sar_q[bit_q] <= comparator_high ^ sar_q[SAC_SIGN_BIT];
                                end
                                if (bit_q == 4'h0) begin
                                    st_q <= ST_IDLE;
                                end else begin
                                    bit_q <= bit_q - 4'h1;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
            endcase
        end
    end
    assign done = (st_q == ST_TRIAL) && (bit_q == 4'h0) && !cal_req && !start;

    // ****************************************************************
    // Trial word to the DAC
    // ****************************************************************
    // Combinational so the comparator answers within the same trial cycle
    // Current trial word goes to the DAC; sign bit is already decided below
    always_comb begin
        trial_value = sar_q;
        if (st_q == ST_TRIAL && bit_q != 4'(SAC_SIGN_BIT)) begin
            trial_value[bit_q] = 1'b1;
        end
    end

    // ****************************************************************
    // Result latch, flags and readout
    // ****************************************************************
    logic second_q;
    logic rd_active;
    assign rd_active = sel && !c.read_n;

    // Latch cycle raises busy together with the interrupt falling
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            conv_active_n <= 1'b0;
        end else if (clk_en) begin
            conv_active_n <= !busy_state(st_q) || done;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            result_q <= '0;
        end else if (clk_en && done) begin
            result_q <= {sar_q[SAC_RES_W-1:1], comparator_high ^ sar_q[SAC_SIGN_BIT]};
        end
    end

    // A new result wins over a read in the same cycle; a start or calibration request blocks it
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            result_ready_n <= 1'b1;
        end else if (clk_en) begin
            if (done) begin
                result_ready_n <= 1'b0;
            end else if (rd_active || start || cal_req) begin
                result_ready_n <= 1'b1;
            end
        end
    end

    // Pointer moves as each read ends; a new result points back at the high byte
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            second_q <= 1'b0;
        end else if (clk_en) begin
            if (done) begin
                second_q <= 1'b0;
            end else if (rd_rise && sel) begin
                second_q <= !second_q;
            end
        end
    end

    // ****************************************************************
    // Data bus
    // ****************************************************************
    // Sign extension fills the upper four lines of the first byte
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            bus_out <= '0;
        end else if (clk_en) begin
            bus_out.data_bus_line_oe <= '0;
            bus_out.data_bus_line_o  <= '0;
            if (rd_active) begin
                bus_out.data_bus_line_oe <= 8'hff;
                bus_out.data_bus_line_o  <= second_q ? result_q[7:0]
                    : {{4{result_q[SAC_SIGN_BIT]}}, result_q[SAC_MSB_BIT:8]};
            end else if (test_mode) begin
                bus_out.data_bus_line_oe <= SAC_TEST_MASK;
                bus_out.data_bus_line_o  <= sar_q[7:0] & SAC_TEST_MASK;
            end
        end
    end

    // ****************************************************************
    // Status flags
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sampling <= 1'b0;
        end else if (clk_en) begin
            sampling <= acq_state(st_q);
        end
    end

    // Reset value matches the power-up calibration that follows release
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            calibrating <= 1'b1;
        end else if (clk_en) begin
            calibrating <= (st_q == ST_CAL);
        end
    end
endmodule
`default_nettype wire

// ---- bench/sac_ctrl_properties.sv ----
// Port checker of the converter control interface
`default_nettype none
module sac_ctrl_properties
    import sac_pkg::*;
(
    input wire logic                 mclk,
    input wire logic                 resetn,
    input wire logic                 clk_en,
    input wire sac_ctrl_t            ctrl_in,
    input wire logic                 comparator_high,
    input wire sac_bus_t             bus_out,
    input wire logic [SAC_RES_W-1:0] trial_value,
    input wire logic                 conv_active_n,
    input wire logic                 result_ready_n,
    input wire logic                 sampling,
    input wire logic                 calibrating
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Helper counters
    // ****************************************************************
    logic [3:0]  cs_hi_q;
    logic [10:0] cal_q;
    always_ff @(posedge mclk) begin
        if (!resetn || !ctrl_in.chip_select_n) cs_hi_q <= 4'h0;
        else if (cs_hi_q != 4'hf) cs_hi_q <= cs_hi_q + 4'h1;
    end
    // Saturates well above the calibration length
    always_ff @(posedge mclk) begin
        if (!resetn || !calibrating) cal_q <= 11'h000;
        else if (cal_q != 11'h7ff) cal_q <= cal_q + 11'h001;
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_cs_idle; cs_hi_q == 4'hf |-> bus_out.data_bus_line_oe == 8'h00; endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("bus driven while deselected");
    property p_cal_low; calibrating |-> !conv_active_n; endproperty
    a_cal_low: assert property (p_cal_low) else $error("busy high in calibration");
    property p_cal_len; $fell(calibrating) |-> cal_q >= 11'd1397 && cal_q <= 11'd1401; endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
    property p_latch; $fell(result_ready_n) |-> $rose(conv_active_n); endproperty
    a_latch: assert property (p_latch) else $error("busy not ending after latch");
    property p_cal_irq; $rose(calibrating) |-> ##[0:2] result_ready_n; endproperty
    a_cal_irq: assert property (p_cal_irq) else $error("interrupt kept in calibration");
    property p_hold; $fell(sampling) && !calibrating |-> ##[0:1] !conv_active_n; endproperty
    a_hold: assert property (p_hold) else $error("busy not low after sampling");
    property p_trial; $fell(sampling) && !calibrating |-> ##[12:14] $fell(result_ready_n); endproperty
    a_trial: assert property (p_trial) else $error("bit trials took wrong time");
    property p_rd_clear; (!ctrl_in.chip_select_n && !ctrl_in.read_n)[*7] |-> result_ready_n;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("read left interrupt low");
    c_result: cover property ($fell(result_ready_n));
    c_cal_end: cover property ($fell(calibrating));
    c_drive: cover property (bus_out.data_bus_line_oe == 8'hff);
endmodule
bind sac_ctrl sac_ctrl_properties u_props (.mclk, .resetn, .clk_en, .ctrl_in, .comparator_high,
    .bus_out, .trial_value, .conv_active_n, .result_ready_n, .sampling, .calibrating);
`default_nettype wire

// ---- bench/sac_host_model.sv ----
// Host and comparator model facing the converter control interface
`default_nettype none
module sac_host_model
    import sac_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic [SAC_RES_W-1:0] trial_value,
    output var  sac_ctrl_t            ctrl,
    output var  logic                 comparator_high
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] target = 12'h000;
    // Positive inputs only: negative trial sense is left to the design
    assign comparator_high = (trial_value[11:0] <= target);
    // Idle keeps calibration request high before any start
    initial ctrl = 6'h3f;
    task automatic set_ctrl(input logic [5:0] v, input int n);
        @(posedge mclk);
        ctrl <= v;
        repeat (n) @(posedge mclk);
        #1;
    endtask
endmodule
`default_nettype wire

// ---- bench/sac_ctrl_tb_top.sv ----
// Self-checking testbench of the converter control interface
`default_nettype none
module sac_ctrl_tb_top
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 mclk = 1'b0;
    logic                 resetn = 1'b0;
    sac_ctrl_t            ctrl;
    logic                 comparator_high;
    sac_bus_t             bus_out;
    logic [SAC_RES_W-1:0] trial_value;
    logic                 conv_active_n;
    logic                 result_ready_n;
    logic                 sampling;
    logic                 calibrating;
    int                   miscompares = 0;
    int                   checks_done = 0;
    always #25 mclk = ~mclk;
    sac_ctrl dut (.mclk, .resetn, .clk_en(1'b1), .ctrl_in(ctrl), .comparator_high, .bus_out,
        .trial_value, .conv_active_n, .result_ready_n, .sampling, .calibrating);
    sac_host_model host (.mclk, .trial_value, .ctrl, .comparator_high);
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait; running out ends the run as a failure
    task automatic wait_on(input bit irq, input logic lvl, input int bound, output int n);
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while ((irq ? result_ready_n : conv_active_n) !== lvl && n < bound);
        if ((irq ? result_ready_n : conv_active_n) !== lvl) begin
            miscompares++;
            finish_test();
        end
    endtask
    task automatic t_cal(input bit req);
        int n;
        if (req) host.set_ctrl(6'h3d, 2);
        if (req) host.set_ctrl(6'h3f, 4);
        chk(calibrating, 1'b1);
        wait_on(1'b0, 1'b1, 2000, n);
        chk(n >= 1385 && n <= 1405, 1'b1);
        chk(result_ready_n, 1'b1);
        $display("test cal %0d done", req);
    endtask
    // Mode 0 write, 1 write with offset null, 2 sample/hold
    task automatic t_conv(input int mode, input logic [11:0] v, output int n);
        logic [5:0] b;
        b = (mode == 1) ? 6'h00 : 6'h01;
        host.target = v;
        if (mode == 2) begin
            host.set_ctrl(6'h1b, 10);
            chk(sampling, 1'b1);
        end else begin
            host.set_ctrl(6'h16 | b, 2);
        end
        host.set_ctrl(6'h1e | b, 0);
        wait_on(1'b1, 1'b0, 300, n);
        host.set_ctrl(6'h0e | b, 8);
        chk(bus_out, {4'h0, v[11:8], 8'hff});
        chk(result_ready_n, 1'b1);
        host.set_ctrl(6'h1e | b, 8);
        host.set_ctrl(6'h0e | b, 8);
        chk(bus_out, {v[7:0], 8'hff});
        host.set_ctrl(6'h3f, 8);
        chk(bus_out.data_bus_line_oe, 8'h00);
        $display("test conv mode %0d done", mode);
    endtask
    task automatic t_misc();
        host.set_ctrl(6'h37, 2);
        host.set_ctrl(6'h3f, 30);
        chk({sampling, conv_active_n, result_ready_n}, 3'b011);
        host.set_ctrl(6'h1d, 8);
        chk(bus_out.data_bus_line_oe, SAC_TEST_MASK);
        host.set_ctrl(6'h3f, 8);
        $display("test ignore and check state done");
    endtask
    initial begin
        int n0;
        int n1;
        int n2;
        repeat (8) @(posedge mclk);
        #1;
        chk({conv_active_n, result_ready_n, calibrating}, 3'b011);
        @(posedge mclk);
        resetn <= 1'b1;
        t_cal(1'b0);
        t_cal(1'b1);
        t_conv(0, 12'ha5c, n0);
        t_conv(0, 12'h000, n2);
        t_conv(1, 12'hfff, n1);
        chk(n1 - n0, 16'd26);
        t_conv(2, 12'h001, n2);
        t_misc();
        finish_test();
    end
endmodule
`default_nettype wire
